// [tb/testbench.sv]
// Purpose: Self-checking bench of the two-wire EEPROM slave.
// Assumes: The master model drives SCL and SDA; SDA has a pull-up.
// Notes:   The write cycle is shortened to 200 clocks.
`timescale 1ns/1ps
`include "twes_defines.svh"
module testbench;
    localparam int unsigned TWC = 200;
    logic       clk;
    logic       rstn;
    logic       wp;
    wire  logic scl;
    wire  logic msda;
    wire  logic sda_o;
    wire  logic sda_oe;
    wire  logic busy;
    wire  logic sda_w;
    int         bad_count;
    int         n_tests;

    // The wire is low while either party pulls it.
    assign sda_w = msda & ~(sda_oe & ~sda_o);

    twes_slave #(.TWC_CYCLES(TWC)) i_dut (
        .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda_w),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_wp(wp), .o_busy(busy)
    );
    twes_master_model i_mst (.o_scl(scl), .o_sda(msda), .i_sda(sda_w));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(string what, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [7:0] ctl(logic [10:0] a, logic rd);
        return {`TWES_TYPE_CODE_DEF, a[10:8], rd};
    endfunction

    task automatic send(logic [7:0] d, logic exp_ack);
        logic ack;
        i_mst.wr_byte(d, ack);
        cmp1("acknowledge", exp_ack, ack);
    endtask

    task automatic wr_page(logic [10:0] a, int n, logic [7:0] base);
        i_mst.start();
        send(ctl(a, 1'b0), 1'b1);
        send(a[7:0], 1'b1);
        for (int i = 0; i < n; i++) begin
            send(base + 8'(i), 1'b1);
        end
        i_mst.stop();
    endtask

    task automatic rd_seq(logic [10:0] a, int n, logic [7:0] base, bit cur);
        logic [7:0] d;
        if (!cur) begin
            i_mst.start();
            send(ctl(a, 1'b0), 1'b1);
            send(a[7:0], 1'b1);
        end
        i_mst.start();
        send(ctl(a, 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            i_mst.rd_byte(i < n - 1, d);
            cmp8("read data", base + 8'(i), d);
        end
        cmp1("sda released", 1'b0, sda_oe);
        i_mst.stop();
        cmp1("busy after read", 1'b0, busy);
    endtask

    task automatic poll(logic exp_busy);
        logic ack;
        int   k;
        k = 0;
        cmp1("busy after stop", exp_busy, busy);
        do begin
            i_mst.start();
            i_mst.wr_byte(ctl(11'h0, 1'b0), ack);
            i_mst.stop();
            k++;
            if (k == 1) begin
                cmp1("first poll", ~exp_busy, ack);
            end
        end while (ack !== 1'b1 && k < 20);
        cmp1("poll done", 1'b1, ack);
        if (ack !== 1'b1) begin
            final_report();
        end
    endtask

    task automatic t_byte();
        wr_page(11'h123, 1, 8'ha5);
        poll(1'b1);
        rd_seq(11'h123, 1, 8'ha5, 1'b0);
        $display("byte write test done");
    endtask

    task automatic t_page();
        wr_page(11'h2fe, 18, 8'h10);
        poll(1'b1);
        rd_seq(11'h2f0, 16, 8'h12, 1'b0);
        $display("page write test done");
    endtask

    task automatic t_wrap();
        wr_page(11'h7ff, 1, 8'h5a);
        poll(1'b1);
        wr_page(11'h000, 1, 8'hc3);
        poll(1'b1);
        rd_seq(11'h7ff, 1, 8'h5a, 1'b0);
        rd_seq(11'h000, 1, 8'hc3, 1'b1);
        $display("wrap test done");
    endtask

    task automatic t_code();
        for (int c = 0; c < 16; c++) begin
            i_mst.start();
            send({4'(c), 3'h0, 1'b0}, 4'(c) == `TWES_TYPE_CODE_DEF);
            i_mst.stop();
        end
        $display("type code test done");
    endtask

    task automatic t_wp();
        @(negedge clk) wp <= 1'b1;
        repeat (10) @(negedge clk);
        wr_page(11'h123, 1, 8'h77);
        poll(1'b0);
        @(negedge clk) wp <= 1'b0;
        rd_seq(11'h123, 1, 8'ha5, 1'b0);
        $display("write protect test done");
    endtask

    task automatic t_abort();
        i_mst.start();
        send(ctl(11'h7ff, 1'b0), 1'b1);
        send(8'hff, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_mst.put_bit(1'b0);
        end
        i_mst.start();
        send(ctl(11'h7ff, 1'b0), 1'b1);
        i_mst.stop();
        cmp1("busy after abort", 1'b0, busy);
        rd_seq(11'h7ff, 1, 8'h5a, 1'b0);
        $display("abort test done");
    endtask

    initial begin
        rstn = 1'b0;
        wp = 1'b0;
        bad_count = 0;
        n_tests = 0;
        repeat (5) @(negedge clk);
        rstn <= 1'b1;
        repeat (10) @(negedge clk);
        t_byte();
        t_page();
        t_wrap();
        t_code();
        t_wp();
        t_abort();
        final_report();
    end

    initial begin
        #400000;
        bad_count++;
        $display("BAD run time limit expected end seen hang");
        final_report();
    end
endmodule // testbench

// [tb/twes_master_model.sv]
// Purpose: Behavioural two-wire bus master facing the slave.
// Assumes: SDA has a pull-up; i_sda is the resolved wire.
// Notes:   A bit lasts 125 ns: 85 ns low, 40 ns high.
`timescale 1ns/1ps
module twes_master_model (
    // Bus lines
    output logic      o_scl,
    output logic      o_sda,
    input  wire logic i_sda
);
    // The bus idles with both lines released high.
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // One clock pulse; data changes only mid-low.
    task automatic put_bit(input logic b);
        o_scl = 1'b0;
        #42.5;
        o_sda = b;
        #42.5;
        o_scl = 1'b1;
        #40;
    endtask

    task automatic get_bit(output logic b);
        o_scl = 1'b0;
        #42.5;
        o_sda = 1'b1;
        #42.5;
        o_scl = 1'b1;
        #20;
        b = i_sda;
        #20;
    endtask

    task automatic start();
        if (!(o_scl && i_sda)) begin
            put_bit(1'b1);
        end
        o_sda = 1'b0;
        #40;
    endtask

    task automatic stop();
        put_bit(1'b0);
        o_sda = 1'b1;
        #200;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(~ack);
    endtask
endmodule // twes_master_model

// [tb/twes_slave_asserts.sv]
// Purpose: Port checker of the two-wire EEPROM slave.
// Assumes: Bound to twes_slave; one clock domain.
// Notes:   Busy length is measured by a helper counter.
`timescale 1ns/1ps
module twes_slave_asserts #(
    parameter int unsigned TWC_CYCLES = 625000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Observed ports
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic i_wp,
    input wire logic o_busy
);
    logic [19:0] busy_cnt_reg;

    // Counts the cycles of one busy interval.
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !o_busy) begin
            busy_cnt_reg <= 20'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 20'h1;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sda_zero_a: assert property (o_sda_o == 1'b0)
        else $error("sda output value not zero");
    oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda drive changed while scl high");
    ack_hold_a: assert property ($rose(i_scl) && o_sda_oe |-> o_sda_oe [*5])
        else $error("sda drive dropped during scl high");
    oe_timing_a: assert property ($rose(o_sda_oe) |-> !i_scl && $past(i_scl, 8))
        else $error("sda drive started away from scl fall");
    busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_reg == 20'(TWC_CYCLES))
        else $error("write cycle length wrong");
    busy_max_a: assert property (busy_cnt_reg <= 20'(TWC_CYCLES))
        else $error("write cycle too long");
    busy_quiet_a: assert property (o_busy |-> !o_sda_oe)
        else $error("sda driven during write cycle");
    wp_block_a: assert property ($rose(o_busy) |-> !i_wp && !$past(i_wp, 8))
        else $error("write cycle started while protected");
    busy_stop_a: assert property ($rose(o_busy) |-> i_scl && i_sda && !$past(i_sda, 8))
        else $error("write cycle started without stop");

    cover property ($rose(o_busy));
    cover property ($rose(o_sda_oe) && i_wp);
    cover property (o_sda_oe && i_scl);
endmodule // twes_slave_asserts

bind twes_slave twes_slave_asserts #(.TWC_CYCLES(TWC_CYCLES)) i_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_wp(i_wp), .o_busy(o_busy)
);

// [verilog/twes_defines.svh]
// Purpose: Named constants of the two-wire EEPROM slave.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef TWES_DEFINES_SVH
`define TWES_DEFINES_SVH
`define TWES_ADDR_W       11
`define TWES_PAGE_W       4
`define TWES_DEPTH        2048
`define TWES_PAGE_SIZE    16
`define TWES_BYTE_BITS    4'h8
`define TWES_CNT_ZERO     4'h0
`define TWES_TYPE_MSB     7
`define TWES_TYPE_LSB     4
`define TWES_BLK_MSB      3
`define TWES_BLK_LSB      1
`define TWES_RW_BIT       0
`define TWES_TYPE_CODE_DEF 4'h5
`define TWES_PINS_IDLE    3'h7
`define TWES_SDA_LOW      1'b0
`define TWES_TWC_MS       5
`define TWES_CLK_KHZ      125000
`define TWES_TWC_CYCLES   (`TWES_TWC_MS * `TWES_CLK_KHZ)
`define TWES_TWC_CNT_W    20
`endif

// [verilog/twes_pkg.sv]
// Purpose: Types of the two-wire EEPROM slave.
// Assumes: Used by scoped names only.
// Notes:   No constants live here.
package twes_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } twes_state_e;

    typedef struct packed {
        logic wp;
        logic scl;
        logic sda;
    } twes_pins_s;
endpackage

// [verilog/twes_slave.sv]
// Purpose: Two-wire serial slave front end of a 2048-byte EEPROM.
// Assumes: SCL and SDA come from an external master; i_clk is much faster than SCL.
// Notes:   SDA is open drain: o_sda_oe high pulls the line low.
// Function
// - Bus idle has both lines high.
// - SDA falling with SCL high is Start.
// - SDA rising with SCL high is Stop.
// - SDA changes only while SCL low.
// - Acknowledge every received addressed byte.
// - Acknowledge holds SDA low through SCL high.
// - No acknowledge during internal programming.
// - Master no-acknowledge releases SDA for Stop.
// - Control byte: type code, block select bits.
// - Control lowest bit: one read, zero write.
// - Acknowledge control byte only on code match.
// - Byte write: control, address, data, acknowledged.
// - Stop after data starts timed write cycle.
// - Write cycle lasts at most five milliseconds.
// - Buffer sixteen bytes, commit page on Stop.
// - Write increments only low four pointer bits.
// - Excess page bytes overwrite earliest in order.
// - Write protect high inhibits all array writes.
// - Current read returns last address plus one.
// - Random read keeps pointer, performs no write.
// - Each sent byte advances pointer; master acknowledge sends next byte.
`timescale 1ns/1ps
`include "twes_defines.svh"
module twes_slave #(
    parameter logic [3:0]  TYPE_CODE  = `TWES_TYPE_CODE_DEF, // Arbitrary value.
    parameter int unsigned TWC_CYCLES = `TWES_TWC_CYCLES,
    parameter int unsigned ADDR_W     = `TWES_ADDR_W,
    parameter int unsigned PAGE_W     = `TWES_PAGE_W
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Two-wire bus
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_o,
    output logic      o_sda_oe,
    // Write protect and status
    input  wire logic i_wp,
    output logic      o_busy
);
    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam int unsigned PSIZE = 1 << PAGE_W;

    logic [2:0]                     pins_q;
    twes_pkg::twes_pins_s           pins;
    twes_pkg::twes_pins_s           prev_reg;
    twes_pkg::twes_state_e          state_reg;
    twes_pkg::twes_state_e          after_reg;
    logic [3:0]                     cnt_reg;
    logic                           ack_phase_reg;
    logic                           mack_reg;
    logic [7:0]                     shift_reg;
    logic [ADDR_W-1:0]              ptr_reg;
    logic [2:0]                     blk_reg;
    logic                           wr_pend_reg;
    logic [7:0]                     page_reg [PSIZE];
    logic [PSIZE-1:0]               valid_reg;
    logic [7:0]                     mem_reg [DEPTH];
    logic [7:0]                     mem_rd;
    logic                           busy;
    logic                           scl_rise;
    logic                           scl_fall;
    logic                           start_det;
    logic                           stop_det;
    logic                           rx_state;
    logic                           rx_shift;
    logic                           byte_end;
    logic                           ctrl_ok;
    logic                           give_ack;
    logic                           ack_end;
    logic                           tx_load;
    logic                           addr_take;
    logic                           data_take;
    logic                           launch;
    logic                           abort;
    logic                           busy_reg;
    twes_pkg::twes_state_e          ctrl_next;

    // Input synchroniser for write protect, clock and data lines.
    // SCL and SDA share one pipeline, so their relative order survives.
    twes_sync #(
        .W       (3),
        .RST_VAL (`TWES_PINS_IDLE)
    ) u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    ({i_wp, i_scl, i_sda}),
        .o_q    (pins_q)
    );

    assign pins = twes_pkg::twes_pins_s'(pins_q);

    // Self-timed write cycle.
    twes_wcycle #(
        .CYCLES (TWC_CYCLES),
        .CNT_W  (`TWES_TWC_CNT_W)
    ) u_wcycle (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_start (launch),
        .o_busy  (busy)
    );

    // Previous filtered line levels for edge detection.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            prev_reg <= twes_pkg::twes_pins_s'(`TWES_PINS_IDLE);
        end else begin
            prev_reg <= pins;
        end
    end

    // Bus events.
    assign scl_rise  = pins.scl & ~prev_reg.scl;
    assign scl_fall  = ~pins.scl & prev_reg.scl;
    assign start_det = pins.scl & prev_reg.scl & prev_reg.sda & ~pins.sda;
    assign stop_det  = pins.scl & prev_reg.scl & ~prev_reg.sda & pins.sda;
    assign abort     = start_det | stop_det;

    // Byte framing decode.
    assign rx_state = (state_reg == twes_pkg::ST_CTRL) ||
                      (state_reg == twes_pkg::ST_ADDR) ||
                      (state_reg == twes_pkg::ST_WDATA);
    assign rx_shift = rx_state && scl_rise && !ack_phase_reg && (cnt_reg != `TWES_BYTE_BITS);
    assign byte_end = scl_fall && !ack_phase_reg && (cnt_reg == `TWES_BYTE_BITS);
    assign ack_end  = scl_fall && ack_phase_reg;
    assign ctrl_ok  = (shift_reg[`TWES_TYPE_MSB:`TWES_TYPE_LSB] == TYPE_CODE) && !busy;
    assign ctrl_next = shift_reg[`TWES_RW_BIT] ? twes_pkg::ST_RDATA : twes_pkg::ST_ADDR;

    // Acknowledge decision at the end of each received byte.
    assign give_ack = byte_end && !start_det && !stop_det &&
                      (((state_reg == twes_pkg::ST_CTRL) && ctrl_ok) ||
                       (state_reg == twes_pkg::ST_ADDR) ||
                       (state_reg == twes_pkg::ST_WDATA));
    assign addr_take = byte_end && (state_reg == twes_pkg::ST_ADDR);
    assign data_take = byte_end && (state_reg == twes_pkg::ST_WDATA);

    // Load a read byte after the control acknowledge or a master acknowledge.
    assign tx_load = !start_det && !stop_det &&
                     ((ack_end && (state_reg == twes_pkg::ST_CTRL) &&
                       (after_reg == twes_pkg::ST_RDATA)) ||
                      ((state_reg == twes_pkg::ST_RACK) && scl_fall && mack_reg));

    assign mem_rd = mem_reg[ptr_reg];

    // Write launch on Stop, suppressed while protected.
    assign launch = stop_det && wr_pend_reg && !pins.wp;

    // Protocol state machine.
    // A Start or Stop wins over any byte that is in flight.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg     <= twes_pkg::ST_IDLE;
            after_reg     <= twes_pkg::ST_IDLE;
            cnt_reg       <= `TWES_CNT_ZERO;
            ack_phase_reg <= 1'b0;
            mack_reg      <= 1'b0;
        end else if (start_det) begin
            state_reg     <= twes_pkg::ST_CTRL;
            cnt_reg       <= `TWES_CNT_ZERO;
            ack_phase_reg <= 1'b0;
            mack_reg      <= 1'b0;
        end else if (stop_det) begin
            state_reg     <= twes_pkg::ST_IDLE;
            cnt_reg       <= `TWES_CNT_ZERO;
            ack_phase_reg <= 1'b0;
            mack_reg      <= 1'b0;
        end else begin
            unique case (state_reg)
                twes_pkg::ST_IDLE: begin
                    cnt_reg <= `TWES_CNT_ZERO;
                end
                twes_pkg::ST_CTRL,
                twes_pkg::ST_ADDR,
                twes_pkg::ST_WDATA: begin
                    if (rx_shift) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (byte_end) begin
                        if (give_ack) begin
                            ack_phase_reg <= 1'b1;
                            if (state_reg == twes_pkg::ST_CTRL) begin
                                after_reg <= ctrl_next;
                            end else begin
                                after_reg <= twes_pkg::ST_WDATA;
                            end
                        end else begin
                            state_reg <= twes_pkg::ST_IDLE;
                        end
                    end
                    if (ack_end) begin
                        ack_phase_reg <= 1'b0;
                        cnt_reg       <= `TWES_CNT_ZERO;
                        state_reg     <= after_reg;
                    end
                end
                twes_pkg::ST_RDATA: begin
                    if (scl_rise && (cnt_reg != `TWES_BYTE_BITS)) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (byte_end) begin
                        state_reg <= twes_pkg::ST_RACK;
                        cnt_reg   <= `TWES_CNT_ZERO;
                        mack_reg  <= 1'b0;
                    end
                end
                twes_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (pins.sda) begin
                            state_reg <= twes_pkg::ST_IDLE;
                        end else begin
                            mack_reg <= 1'b1;
                        end
                    end
                    if (scl_fall && mack_reg) begin
                        state_reg <= twes_pkg::ST_RDATA;
                        mack_reg  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Shift register: receive on SCL rise, transmit on SCL fall.
    // Transmit bits follow the same filtered fall that moves SDA.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            shift_reg <= 8'h00;
        end else if (tx_load) begin
            shift_reg <= mem_rd;
        end else if (rx_shift && !start_det && !stop_det) begin
            shift_reg <= {shift_reg[6:0], pins.sda};
        end else if ((state_reg == twes_pkg::ST_RDATA) && scl_fall &&
                     (cnt_reg != `TWES_BYTE_BITS)) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
        end
    end

    // SDA pull-down, changed only on SCL fall.
    // Waiting for the filtered fall keeps SDA still while SCL is high.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_sda_oe <= 1'b0;
        end else if (start_det || stop_det) begin
            o_sda_oe <= 1'b0;
        end else if (give_ack) begin
            o_sda_oe <= 1'b1;
        end else if (tx_load) begin
            o_sda_oe <= ~mem_rd[7];
        end else if (ack_end) begin
            o_sda_oe <= 1'b0;
        end else if ((state_reg == twes_pkg::ST_RDATA) && scl_fall) begin
            if (cnt_reg == `TWES_BYTE_BITS) begin
                o_sda_oe <= 1'b0;
            end else begin
                o_sda_oe <= ~shift_reg[6];
            end
        end else if (state_reg == twes_pkg::ST_IDLE) begin
            o_sda_oe <= 1'b0;
        end
    end

    assign o_sda_o = `TWES_SDA_LOW;
    assign o_busy  = busy_reg;

    // Busy status leaves the block from a flip-flop.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy;
        end
    end

    // Address pointer and block select.
    // Block bits act only with an address byte; a current read keeps the pointer.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ptr_reg <= '0;
            blk_reg <= 3'h0;
        end else if (!start_det && !stop_det) begin
            if (give_ack && (state_reg == twes_pkg::ST_CTRL)) begin
                blk_reg <= shift_reg[`TWES_BLK_MSB:`TWES_BLK_LSB];
            end
            if (addr_take) begin
                ptr_reg <= ADDR_W'({blk_reg, shift_reg});
            end else if (data_take) begin
                ptr_reg[PAGE_W-1:0] <= ptr_reg[PAGE_W-1:0] + 1'b1;
            end else if (byte_end && (state_reg == twes_pkg::ST_RDATA)) begin
                ptr_reg <= ptr_reg + 1'b1;
            end
        end
    end

    // Pending page write; a Start or Stop consumes it.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_pend_reg <= 1'b0;
        end else if (start_det || stop_det || addr_take) begin
            wr_pend_reg <= 1'b0;
        end else if (data_take) begin
            wr_pend_reg <= 1'b1;
        end
    end

    // Page buffer, one entry per low pointer value.
    // A repeated Start discards a page that no Stop has committed.
    genvar gi;
    generate
        for (gi = 0; gi < PSIZE; gi++) begin : g_page
            always_ff @(posedge i_clk) begin
                if (!i_rstn) begin
                    page_reg[gi]  <= 8'h00;
                    valid_reg[gi] <= 1'b0;
                end else if (addr_take || abort) begin
                    valid_reg[gi] <= 1'b0;
                end else if (data_take && !start_det &&
                             (ptr_reg[PAGE_W-1:0] == PAGE_W'(gi))) begin
                    page_reg[gi]  <= shift_reg;
                    valid_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Array commit of the buffered page at launch.
    // The array has no reset; only a launch ever writes it.
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < PSIZE; i++) begin
            if (launch && valid_reg[i]) begin
                mem_reg[{ptr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_reg[i];
            end
        end
    end
endmodule // twes_slave

// [verilog/twes_sync.sv]
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to i_clk.
// Notes:   A bit changes only when the second and third stages agree.
`timescale 1ns/1ps
module twes_sync #(
    parameter int unsigned W       = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Asynchronous inputs and filtered outputs
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] diff;

    assign diff = ff2_reg ^ ff3_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ff1_reg <= RST_VAL;
            ff2_reg <= RST_VAL;
            ff3_reg <= RST_VAL;
            o_q     <= RST_VAL;
        end else begin
            ff1_reg <= i_d;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            o_q     <= (ff2_reg & ~diff) | (o_q & diff);
        end
    end
endmodule // twes_sync

// [verilog/twes_wcycle.sv]
// Purpose: Self-timed write cycle timer.
// Assumes: i_start is a one-cycle pulse.
// Notes:   Busy lasts exactly CYCLES clocks after the start pulse.
`timescale 1ns/1ps
`include "twes_defines.svh"
module twes_wcycle #(
    parameter int unsigned CYCLES = `TWES_TWC_CYCLES,
    parameter int unsigned CNT_W  = `TWES_TWC_CNT_W
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Control and status
    input  wire logic i_start,
    output logic      o_busy
);
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else if (i_start && (cnt_reg == '0)) begin
            cnt_reg <= CNT_W'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign o_busy = (cnt_reg != '0);
endmodule // twes_wcycle
